// *** mtu_regs.svh ***
// register map, field positions, reset values and rates of the timer unit
`ifndef MTU_REGS_SVH
`define MTU_REGS_SVH
`define MTU_ADDR_CTRL    8'h00
`define MTU_ADDR_FLAGS   8'h04
`define MTU_ADDR_ENABLE  8'h08
`define MTU_CNT_BASE     8'h10
`define MTU_CNT_STRIDE   8'h20
`define MTU_OFF_CFG      8'h00
`define MTU_OFF_RLD_HI   8'h04
`define MTU_OFF_RLD_LO   8'h08
`define MTU_OFF_CUR_HI   8'h0c
`define MTU_OFF_CUR_LO   8'h10
`define MTU_CFG_SEL_LSB  0
`define MTU_CFG_RELOAD   2
`define MTU_CFG_START    3
`define MTU_CFG_AUTOSTBY 4
`define MTU_CTRL_APPLY   4
`define MTU_SEL_BIT      7
`define MTU_FLAG_COMB    5
`define MTU_EN_PIN       5
`define MTU_RST_RELOAD   16'h0000
`define MTU_RST_CFG      8'h00
`define MTU_RST_ENABLE   8'h00
`define MTU_MCLK_KHZ     16'd50000
`define MTU_FAST_KHZ     16'd13560
`define MTU_SLOW_KHZ     16'd212
`endif

// *** mtu_pkg.sv ***
// types shared by the timer unit
package mtu_pkg;
    typedef logic [15:0] mtu_count_t;
    typedef enum logic [1:0] {
        MTU_SEL_FAST = 2'b00,
        MTU_SEL_SLOW = 2'b01,
        MTU_SEL_WAKE = 2'b11,
        MTU_SEL_OFF  = 2'b10
    } mtu_clksel_e;
endpackage

// *** mtu_timer_unit.sv ***
// four general down-counters and a wake-up counter behind AXI4-Lite
// Summary of operation
// (RL1) general counters count 13.56 MHz, 212 kHz or wake counter underflows
// (RL2) each counter is 16 bits, reload 0000h-FFFFh in high and low bytes
// (RL3) wake counter always counts the low-power oscillator
// (RL4) shared control starts/stops general counters and shows which run
// (RL5) a running counter decrements each count clock; value readable by bytes
// (RL6) counter at 0000h raises its flag on the next count clock
// (RL7) software can set and clear each underflow flag; hardware also sets it
// (RL8) on underflow halt at 0000h or reload and continue, per config bit
// (RL9) running bit reads set exactly while the counter counts
// (RL10) software writes apply-now with running set to start, clear to stop
// (RL11) start bit in a counter's config register also starts it
// (RL12) stop event before underflow freezes the value, no flag raised
// (RL13) without stop event counter reaches zero and flags one clock later
// (RL14) wake counter wakes from standby; auto-standby re-enters if no card
// (RL15) auto-standby cleared keeps the system powered after empty detection
// (RL16) software ignores stopwatch result while the underflow flag is set
// (RL17) reload plus enabled interrupt gives a request every reload period
// (RL18) each general counter owns a distinct underflow flag
// (RL19) enabled underflow events drive the interrupt request pin
// (RL20) combined flag sets whenever any source flag becomes set
// (RL21) flag/enable writes: bit 7 selects set or clear of bits written one
// (RL22) each start copies the reload value into the counter first
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/100ps
`include "mtu_regs.svh"
module mtu_timer_unit #(
    parameter int NUM_GEN = 4,
    parameter int ADDR_W  = 8
) (
    input  wire logic              mclk,
    input  wire logic              resetn,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    output logic [1:0]             s_axi_bresp,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    input  wire logic              lpoClk,
    input  wire logic [NUM_GEN-1:0] stopEvent,
    input  wire logic              detectDone,
    input  wire logic              cardFound,
    output logic                   irqOut,
    output logic                   wakeUp,
    output logic                   standby,
    output mtu_pkg::mtu_count_t    wakeValue
);
    import mtu_pkg::*;
    localparam int NC = NUM_GEN + 1;
    localparam int WK = NUM_GEN;

    logic              awHave, wHave;
    logic [ADDR_W-1:0] awAddr;
    logic [7:0]        wrData;
    logic              wrEn, wrHit, rdHit;
    logic [31:0]       rdWord;
    logic [15:0]       fastAcc, slowAcc;
    logic              fastTick, slowTick;
    logic [2:0]        lpoSync;
    logic              lpoLvl, lpoTick;
    mtu_count_t        cnt    [NC];
    mtu_count_t        reload [NC];
    logic [7:0]        cfg    [NC];
    logic [NC-1:0]     runs, tick, uf, startReq, stopReq;
    logic [NC-1:0]     flags, enables;
    logic              combFlag, pinEn;
    assign s_axi_awready = !awHave && !s_axi_bvalid;
    assign s_axi_wready  = !wHave && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wrEn = awHave && wHave && !s_axi_bvalid;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            awHave <= 1'b0;
            awAddr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awHave <= 1'b1;
            awAddr <= s_axi_awaddr;
        end else if (wrEn) begin
            awHave <= 1'b0;
        end
    end

    // registers are one byte wide: only lane 0 carries a write
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wHave  <= 1'b0;
            wrData <= 8'h00;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wHave  <= 1'b1;
            wrData <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
        end else if (wrEn) begin
            wHave <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
        end else if (wrEn) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrHit ? 2'b00 : 2'b10;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdWord;
            s_axi_rresp  <= rdHit ? 2'b00 : 2'b10;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    function automatic logic isCnt(input logic [ADDR_W-1:0] a,
                                   input int i, input logic [7:0] off);
        isCnt = a == ADDR_W'(`MTU_CNT_BASE + i * `MTU_CNT_STRIDE + off);
    endfunction
    // read decode works on the incoming address, so data lands with rvalid
    always_comb begin
        rdWord = 32'h0;
        rdHit  = 1'b1;
        wrHit  = 1'b1;
        case (s_axi_araddr)
            ADDR_W'(`MTU_ADDR_CTRL):   rdWord[NUM_GEN-1:0] = runs[NUM_GEN-1:0]; // RL4 RL9
            ADDR_W'(`MTU_ADDR_FLAGS):  rdWord[7:0] = {2'b00, combFlag, flags};
            ADDR_W'(`MTU_ADDR_ENABLE): rdWord[7:0] = {2'b00, pinEn, enables};
            default:                   rdHit = 1'b0;
        endcase
        for (int i = 0; i < NC; i++) begin
            if (isCnt(s_axi_araddr, i, `MTU_OFF_CFG)) begin
                rdWord[7:0] = cfg[i];
                rdHit       = 1'b1;
            end
            if (isCnt(s_axi_araddr, i, `MTU_OFF_RLD_HI)) begin
                rdWord[7:0] = reload[i][15:8];
                rdHit       = 1'b1;
            end
            if (isCnt(s_axi_araddr, i, `MTU_OFF_RLD_LO)) begin
                rdWord[7:0] = reload[i][7:0];
                rdHit       = 1'b1;
            end
            if (isCnt(s_axi_araddr, i, `MTU_OFF_CUR_HI)) begin
                rdWord[7:0] = cnt[i][15:8]; // RL5
                rdHit       = 1'b1;
            end
            if (isCnt(s_axi_araddr, i, `MTU_OFF_CUR_LO)) begin
                rdWord[7:0] = cnt[i][7:0]; // RL5
                rdHit       = 1'b1;
            end
        end
        if (awAddr > ADDR_W'(`MTU_ADDR_ENABLE)) begin
            wrHit = 1'b0;
            for (int i = 0; i < NC; i++) begin
                for (int o = 0; o <= 16; o += 4) begin
                    if (isCnt(awAddr, i, 8'(o))) begin
                        wrHit = 1'b1;
                    end
                end
            end
        end
    end
    // fractional accumulators keep the average rate exact without a PLL
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            fastAcc  <= 16'h0;
            fastTick <= 1'b0;
        end else if (fastAcc >= `MTU_MCLK_KHZ - `MTU_FAST_KHZ) begin
            fastAcc  <= fastAcc + `MTU_FAST_KHZ - `MTU_MCLK_KHZ;
            fastTick <= 1'b1;
        end else begin
            fastAcc  <= fastAcc + `MTU_FAST_KHZ;
            fastTick <= 1'b0;
        end
    end
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            slowAcc  <= 16'h0;
            slowTick <= 1'b0;
        end else if (slowAcc >= `MTU_MCLK_KHZ - `MTU_SLOW_KHZ) begin
            slowAcc  <= slowAcc + `MTU_SLOW_KHZ - `MTU_MCLK_KHZ;
            slowTick <= 1'b1;
        end else begin
            slowAcc  <= slowAcc + `MTU_SLOW_KHZ;
            slowTick <= 1'b0;
        end
    end

    // oscillator is asynchronous: level accepted once stages 2 and 3 agree
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            lpoSync <= 3'b000;
            lpoLvl  <= 1'b0;
        end else begin
            lpoSync <= {lpoSync[1:0], lpoClk};
            if (lpoSync[1] == lpoSync[2]) begin
                lpoLvl <= lpoSync[2];
            end
        end
    end
    assign lpoTick = (lpoSync[1] == lpoSync[2]) && lpoSync[2] && !lpoLvl;
    always_comb begin
        startReq = '0;
        stopReq  = '0;
        if (wrEn && awAddr == ADDR_W'(`MTU_ADDR_CTRL)) begin
            for (int i = 0; i < NUM_GEN; i++) begin
                if (wrData[`MTU_CTRL_APPLY + i]) begin
                    startReq[i] = wrData[i]; // RL10 RL4
                    stopReq[i]  = !wrData[i]; // RL10
                end
            end
        end
        for (int i = 0; i < NC; i++) begin
            if (wrEn && isCnt(awAddr, i, `MTU_OFF_CFG)
                && wrData[`MTU_CFG_START]) begin
                startReq[i] = 1'b1; // RL11
            end
        end
    end
    for (genvar g = 0; g < NC; g++) begin : gCnt
        logic halt;
        if (g == WK) begin : gWake
            assign tick[g] = lpoTick; // RL3
            assign halt    = 1'b0;
        end else begin : gGen
            always_comb begin
                case (mtu_clksel_e'(cfg[g][1:0])) // RL1
                    MTU_SEL_FAST: tick[g] = fastTick;
                    MTU_SEL_SLOW: tick[g] = slowTick;
                    MTU_SEL_WAKE: tick[g] = uf[WK];
                    default:      tick[g] = 1'b0;
                endcase
            end
            assign halt = stopEvent[g] || stopReq[g]; // RL12
        end
        // underflow is the count clock seen while holding zero
        assign uf[g] = runs[g] && tick[g] && cnt[g] == 16'h0000
                       && !halt && !startReq[g]; // RL6 RL13

        always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
                reload[g] <= `MTU_RST_RELOAD;
                cfg[g]    <= `MTU_RST_CFG;
            end else if (wrEn) begin
                if (isCnt(awAddr, g, `MTU_OFF_RLD_HI)) begin
                    reload[g][15:8] <= wrData; // RL2
                end
                if (isCnt(awAddr, g, `MTU_OFF_RLD_LO)) begin
                    reload[g][7:0] <= wrData; // RL2
                end
                if (isCnt(awAddr, g, `MTU_OFF_CFG)) begin
                    cfg[g] <= wrData & ~(8'h01 << `MTU_CFG_START);
                end
            end
        end

        always_ff @(posedge mclk or negedge resetn) begin
            if (!resetn) begin
                runs[g] <= 1'b0;
                cnt[g]  <= 16'h0000;
            end else if (startReq[g]) begin
                runs[g] <= 1'b1; // RL9
                cnt[g]  <= reload[g]; // RL22
            end else if (runs[g] && halt) begin
                runs[g] <= 1'b0; // RL12
            end else if (uf[g]) begin
                if (cfg[g][`MTU_CFG_RELOAD]) begin
                    cnt[g] <= reload[g]; // RL8 RL17
                end else begin
                    runs[g] <= 1'b0; // RL8
                end
            end else if (runs[g] && tick[g]) begin
                cnt[g] <= cnt[g] - 16'h0001; // RL5
            end
        end
    end
    assign wakeValue = cnt[WK];
    logic flagWr, enWr;
    assign flagWr = wrEn && awAddr == ADDR_W'(`MTU_ADDR_FLAGS);
    assign enWr   = wrEn && awAddr == ADDR_W'(`MTU_ADDR_ENABLE);

    // a hardware set in the same cycle as a software clear wins
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            flags    <= '0;
            combFlag <= 1'b0;
        end else begin
            if (flagWr && wrData[`MTU_SEL_BIT]) begin
                flags    <= flags | wrData[NC-1:0] | uf; // RL7 RL21
                combFlag <= combFlag | wrData[`MTU_FLAG_COMB]
                            | (|wrData[NC-1:0]) | (|uf); // RL20
            end else if (flagWr) begin
                flags    <= (flags & ~wrData[NC-1:0]) | uf; // RL7 RL21
                combFlag <= (combFlag & !wrData[`MTU_FLAG_COMB])
                            | (|uf); // RL20
            end else begin
                flags    <= flags | uf; // RL18
                combFlag <= combFlag | (|uf); // RL20
            end
        end
    end
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            enables <= NC'(`MTU_RST_ENABLE);
            pinEn   <= 1'b0;
        end else if (enWr && wrData[`MTU_SEL_BIT]) begin
            enables <= enables | wrData[NC-1:0]; // RL21
            pinEn   <= pinEn | wrData[`MTU_EN_PIN];
        end else if (enWr) begin
            enables <= enables & ~wrData[NC-1:0]; // RL21
            pinEn   <= pinEn & !wrData[`MTU_EN_PIN];
        end
    end
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            irqOut <= 1'b0;
        end else begin
            irqOut <= pinEn && |(flags & enables); // RL19
        end
    end
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            standby <= 1'b0;
            wakeUp  <= 1'b0;
        end else begin
            wakeUp <= uf[WK]; // RL14
            if (uf[WK]) begin
                standby <= 1'b0; // RL14
            end else if (detectDone && !cardFound
                         && cfg[WK][`MTU_CFG_AUTOSTBY]) begin
                standby <= 1'b1; // RL14 RL15
            end
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);

    a_start_loads_reload: assert property ( // RL22
        startReq[0] |=> runs[0] && cnt[0] == $past(reload[0]))
        else $error("start did not load reload value");
    a_tick_decrements: assert property ( // RL5
        runs[0] && tick[0] && cnt[0] != 16'h0 && !startReq[0]
        && !stopEvent[0] && !stopReq[0] |=> cnt[0] == $past(cnt[0]) - 1)
        else $error("running counter did not decrement");
    a_underflow_sets_flag: assert property ( // RL18
        uf[0] |=> flags[0] ##1 flags[0] || $past(flagWr))
        else $error("underflow flag not set");
    a_halt_at_zero: assert property ( // RL8
        uf[0] && !cfg[0][`MTU_CFG_RELOAD] |=> !runs[0] && cnt[0] == 16'h0)
        else $error("counter did not halt at zero");
    a_reload_period: assert property ( // RL17
        uf[0] && cfg[0][`MTU_CFG_RELOAD]
        |=> runs[0] && cnt[0] == $past(reload[0]))
        else $error("counter did not reload on underflow");
    a_stop_freezes_value: assert property ( // RL12
        runs[1] && stopEvent[1] && !startReq[1]
        |-> !uf[1] ##1 !runs[1] && $stable(cnt[1]))
        else $error("stop event did not freeze counter");
    a_idle_holds_value: assert property ( // RL9
        !runs[0] && !startReq[0] |=> !runs[0] && $stable(cnt[0]))
        else $error("stopped counter changed");
    a_combined_flag_set: assert property ( // RL20
        |uf |=> combFlag)
        else $error("combined flag missed a source");
    a_irq_pin_raised: assert property ( // RL19
        uf[0] && enables[0] && pinEn && !enWr ##1 !enWr |=> irqOut)
        else $error("enabled underflow did not reach pin");
    a_clear_select_works: assert property ( // RL21
        flagWr && !wrData[`MTU_SEL_BIT] && wrData[2] && !uf[2]
        |=> !flags[2])
        else $error("selector clear failed");
    a_wake_leaves_standby: assert property ( // RL14
        uf[WK] |=> !standby && wakeUp)
        else $error("wake underflow did not wake");

    c_periodic_underflow: cover property (uf[0] && cfg[0][`MTU_CFG_RELOAD]);
    c_stop_while_running: cover property (runs[1] && stopEvent[1]);
    c_wake_underflow: cover property (uf[WK]);
    c_irq_pin: cover property (irqOut);
endmodule

// *** tb_mtu_timer_unit.sv ***
// self-checking testbench for the multi-counter timer unit
`timescale 1ns/100ps
`include "mtu_regs.svh"
`define CHK(got, exp) begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
        n_fail++; \
        $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp); \
    end \
end
module tb_mtu_timer_unit;
    import mtu_pkg::*;
    logic        mclk = 1'b0;
    logic        resetn = 1'b0;
    logic        s_axi_awvalid = 1'b0;
    logic        s_axi_awready;
    logic [7:0]  s_axi_awaddr = 8'h00;
    logic        s_axi_wvalid = 1'b0;
    logic        s_axi_wready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0]  s_axi_wstrb = 4'h1;
    logic        s_axi_bvalid;
    logic        s_axi_bready = 1'b0;
    logic [1:0]  s_axi_bresp;
    logic        s_axi_arvalid = 1'b0;
    logic        s_axi_arready;
    logic [7:0]  s_axi_araddr = 8'h00;
    logic        s_axi_rvalid;
    logic        s_axi_rready = 1'b0;
    logic [31:0] s_axi_rdata;
    logic [1:0]  s_axi_rresp;
    logic        lpoClk = 1'b0;
    logic [3:0]  stopEvent = 4'h0;
    logic        detectDone = 1'b0;
    logic        cardFound = 1'b0;
    logic        irqOut;
    logic        wakeUp;
    logic        standby;
    mtu_count_t  wakeValue;
    logic [1:0]  resp;
    logic [31:0] rdat;
    int          n_fail = 0;
    int          comparisons = 0;
    int          seed = 32'h1ebfbe4e;

    mtu_timer_unit u_mtu_timer_unit (
        .mclk, .resetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
        .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
        .s_axi_rdata, .s_axi_rresp, .lpoClk, .stopEvent, .detectDone,
        .cardFound, .irqOut, .wakeUp, .standby, .wakeValue
    );

    always #10 mclk = ~mclk;
    // oscillator deliberately unrelated in phase to mclk
    always #155 lpoClk = ~lpoClk;

    function automatic logic [7:0] cad(input int i, input logic [7:0] off);
        return `MTU_CNT_BASE + `MTU_CNT_STRIDE * i[7:0] + off;
    endfunction

    function automatic logic [7:0] cfg(input mtu_clksel_e s, input logic rl,
                                       input logic st, input logic sb);
        return {3'b000, sb, st, rl, s};
    endfunction

    // bit 7 chooses set or clear of the bits written as one
    function automatic logic [7:0] selwr(input logic [7:0] cur,
                                         input logic [7:0] w);
        return w[7] ? (cur | {1'b0, w[6:0]}) : (cur & ~{1'b0, w[6:0]});
    endfunction

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bit aw;
        bit w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge mclk);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr  <= a;
        s_axi_wvalid  <= 1'b1;
        s_axi_wdata   <= {24'h0, d};
        s_axi_bready  <= 1'b1;
        while (!(aw && w)) begin
            @(posedge mclk);
            if (!aw && s_axi_awready === 1'b1) begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w && s_axi_wready === 1'b1) begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge mclk); while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge mclk);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr  <= a;
        s_axi_rready  <= 1'b1;
        do @(posedge mclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge mclk); while (s_axi_rvalid !== 1'b1);
        rdat = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        rd(a);
        `CHK(rdat, {24'h0, e})
    endtask

    task automatic load(input int i, input logic [15:0] v);
        wr(cad(i, `MTU_OFF_RLD_HI), v[15:8]);
        wr(cad(i, `MTU_OFF_RLD_LO), v[7:0]);
    endtask

    // polls the flag register; bounded so a dead counter cannot hang
    task automatic wait_flag(input int b);
        for (int k = 0; k < 400; k++) begin
            rd(`MTU_ADDR_FLAGS);
            if (rdat[b] === 1'b1) break;
        end
        `CHK(rdat[b], 1'b1)
    endtask

    task automatic wait_wake();
        for (int k = 0; k < 400 && wakeUp !== 1'b1; k++) @(posedge mclk);
        `CHK(wakeUp, 1'b1)
        repeat (2) @(posedge mclk);
    endtask

    task automatic det(input logic c);
        @(posedge mclk);
        detectDone <= 1'b1;
        cardFound  <= c;
        @(posedge mclk);
        detectDone <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask

    task close_out;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        #(60000 * 20);
        n_fail++;
        close_out();
    end

    initial begin
        logic [15:0] v;
        logic [7:0]  a;
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        @(posedge mclk);
        `CHK({irqOut, wakeUp, standby}, 3'b000)
        rchk(`MTU_ADDR_CTRL, 8'h00);
        rchk(`MTU_ADDR_FLAGS, 8'h00);
        rchk(`MTU_ADDR_ENABLE, `MTU_RST_ENABLE);
        for (int i = 0; i < 5; i++) begin
            rchk(cad(i, `MTU_OFF_CFG), `MTU_RST_CFG);
            rchk(cad(i, `MTU_OFF_RLD_LO), 8'h00);
        end
        // unmapped hole between enable and the first counter
        rd(8'h0c);
        `CHK(resp, 2'b10)
        wr(8'h0c, 8'hff);
        `CHK(resp, 2'b10)
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 16'hffff : (i == 1) ? 16'h0000 : 16'($random(seed));
            load(i % 4, v);
            rchk(cad(i % 4, `MTU_OFF_RLD_HI), v[15:8]);
            rchk(cad(i % 4, `MTU_OFF_RLD_LO), v[7:0]);
        end
        wr(`MTU_ADDR_FLAGS, 8'h8a);
        rchk(`MTU_ADDR_FLAGS, selwr(8'h00, 8'h8a) | 8'h20);
        wr(`MTU_ADDR_FLAGS, 8'h02);
        rchk(`MTU_ADDR_FLAGS, selwr(8'h2a, 8'h02));
        wr(`MTU_ADDR_FLAGS, 8'h28);
        rchk(`MTU_ADDR_FLAGS, 8'h00);
        wr(`MTU_ADDR_ENABLE, 8'ha1);
        rchk(`MTU_ADDR_ENABLE, selwr(8'h00, 8'ha1));
        wr(`MTU_ADDR_ENABLE, 8'h20);
        // one-shot on the fast clock, halts at zero
        load(0, 16'h0005);
        wr(cad(0, `MTU_OFF_CFG), cfg(MTU_SEL_FAST, 1'b0, 1'b0, 1'b0));
        wr(`MTU_ADDR_CTRL, 8'h11);
        rchk(`MTU_ADDR_CTRL, 8'h01);
        wait_flag(0);
        rchk(`MTU_ADDR_CTRL, 8'h00);
        rchk(cad(0, `MTU_OFF_CUR_LO), 8'h00);
        rchk(`MTU_ADDR_FLAGS, 8'h21);
        // periodic with the request pin
        wr(`MTU_ADDR_FLAGS, 8'h21);
        wr(`MTU_ADDR_ENABLE, 8'ha1);
        wr(cad(0, `MTU_OFF_CFG), cfg(MTU_SEL_FAST, 1'b1, 1'b0, 1'b0));
        wr(`MTU_ADDR_CTRL, 8'h11);
        wait_flag(0);
        repeat (3) @(posedge mclk);
        `CHK(irqOut, 1'b1)
        wr(`MTU_ADDR_FLAGS, 8'h01);
        wait_flag(0);
        rchk(`MTU_ADDR_CTRL, 8'h01);
        wr(`MTU_ADDR_ENABLE, 8'h20);
        repeat (3) @(posedge mclk);
        `CHK(irqOut, 1'b0)
        wr(`MTU_ADDR_CTRL, 8'h10);
        rchk(`MTU_ADDR_CTRL, 8'h00);
        // stop event well before underflow
        wr(`MTU_ADDR_FLAGS, 8'h3f);
        load(1, 16'h00ff);
        wr(cad(1, `MTU_OFF_CFG), cfg(MTU_SEL_FAST, 1'b0, 1'b0, 1'b0));
        wr(`MTU_ADDR_CTRL, 8'h22);
        repeat (20) @(posedge mclk);
        stopEvent <= 4'h2;
        @(posedge mclk);
        stopEvent <= 4'h0;
        rchk(`MTU_ADDR_CTRL, 8'h00);
        rchk(`MTU_ADDR_FLAGS, 8'h00);
        rd(cad(1, `MTU_OFF_CUR_LO));
        a = rdat[7:0];
        `CHK(a < 8'hff, 1'b1)
        repeat (50) @(posedge mclk);
        rchk(cad(1, `MTU_OFF_CUR_LO), a);
        rchk(`MTU_ADDR_FLAGS, 8'h00);
        // start through the config start bit on the slow clock
        load(2, 16'h1234);
        wr(cad(2, `MTU_OFF_CFG), cfg(MTU_SEL_SLOW, 1'b0, 1'b1, 1'b0));
        rchk(`MTU_ADDR_CTRL, 8'h04);
        rchk(cad(2, `MTU_OFF_CUR_HI), 8'h12);
        rchk(cad(2, `MTU_OFF_CFG), cfg(MTU_SEL_SLOW, 1'b0, 1'b0, 1'b0));
        wr(`MTU_ADDR_CTRL, 8'h40);
        // counter 3 counts wake underflows; set up before the wake start
        load(3, 16'h0001);
        wr(cad(3, `MTU_OFF_CFG), cfg(MTU_SEL_WAKE, 1'b0, 1'b0, 1'b0));
        wr(`MTU_ADDR_CTRL, 8'h88);
        load(4, 16'h0003);
        wr(cad(4, `MTU_OFF_CFG), cfg(MTU_SEL_FAST, 1'b1, 1'b1, 1'b1));
        wait_wake();
        `CHK(wakeValue, 16'h0003)
        `CHK(standby, 1'b0)
        det(1'b1);
        `CHK(standby, 1'b0)
        det(1'b0);
        `CHK(standby, 1'b1)
        wait_wake();
        `CHK(standby, 1'b0)
        wait_flag(3);
        wr(cad(4, `MTU_OFF_CFG), cfg(MTU_SEL_FAST, 1'b1, 1'b0, 1'b0));
        det(1'b0);
        `CHK(standby, 1'b0)
        close_out();
    end
endmodule
